// File: bench/ebus_asserts.sv
// Purpose: pin-level checks of the access engine
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every engine instance below
module ebus_asserts
  import ebus_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic        i_req_valid,
  input wire req_t        i_req,
  input wire logic        i_sdram_bus16,
  input wire logic        i_area5_card_enable,
  input wire logic        o_req_ready,
  input wire logic        o_done,
  input wire logic [25:0] o_addr,
  input wire logic [6:0]  o_cs_n,
  input wire logic        o_io_cycle,
  input wire sdcmd_t      o_sd_cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  logic take;
  logic mode_req;
  // accepted request, and whether it hits a mode window
  assign take = i_req_valid && o_req_ready;
  assign mode_req = take && i_req.write && i_req.size == SZ_BYTE &&
    (i_req.addr[31:12] == MODE_WIN_A2 || i_req.addr[31:12] == MODE_WIN_A3);
  // mode set steps
  sequence pall_s; o_sd_cmd == CMD_PALL; endsequence
  sequence mrs_s; o_sd_cmd == CMD_MRS; endsequence
  sequence fin_s; o_done && o_sd_cmd == CMD_NOP; endsequence
  AST_MODE_START: assert property (mode_req |=> pall_s ##1 mrs_s ##1 fin_s)
    else $error("mode set sequence wrong");
  AST_PALL_MRS: assert property (pall_s |=> mrs_s)
    else $error("precharge not followed by mode set");
  AST_ADDR32: assert property (o_sd_cmd == CMD_MRS && !i_sdram_bus16 |->
    o_addr[15:9] == MODE_WRITE_CODE && o_addr[5:2] == {MODE_SEQ_TYPE, MODE_BURST_ONE})
    else $error("mode address wrong for 32-bit bus");
  AST_ADDR16: assert property (o_sd_cmd == CMD_MRS && i_sdram_bus16 |->
    o_addr[14:8] == MODE_WRITE_CODE && o_addr[4:1] == {MODE_SEQ_TYPE, MODE_BURST_ONE})
    else $error("mode address wrong for 16-bit bus");
  AST_CS_HELD: assert property (o_cs_n != CS_IDLE && !o_done |=> o_done || $stable(o_cs_n))
    else $error("chip select moved inside an access");
  AST_BUSY: assert property (take |=> !o_req_ready)
    else $error("ready while busy");
  AST_MIN_LEN: assert property (take && !mode_req |=> !o_done [*2])
    else $error("access finished too early");
  AST_IO: assert property (take && i_area5_card_enable &&
    i_req.addr[28:25] == IO_WIN_A5 |-> ##[1:3] o_io_cycle)
    else $error("io card timing missing");
  AST_NOT_IO: assert property (take && i_req.addr[28:26] == AREA0 |=> !o_io_cycle [*2])
    else $error("io timing outside card area");
endmodule

bind ebus_engine ebus_asserts chk (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_req_valid(i_req_valid), .i_req(i_req), .i_sdram_bus16(i_sdram_bus16),
  .i_area5_card_enable(i_area5_card_enable), .o_req_ready(o_req_ready), .o_done(o_done),
  .o_addr(o_addr), .o_cs_n(o_cs_n), .o_io_cycle(o_io_cycle), .o_sd_cmd(o_sd_cmd));

// File: bench/ext_mem_model.sv
// Purpose: rom and card on the far side of the engine pins
// Assumes: read data repeats the low address byte on every lane
// Notes:   i_stall sets wait length after each address or strobe step
module ext_mem_model (
  input  wire logic        i_clk,
  input  wire logic [25:0] i_addr,
  input  wire logic        i_cs_any,
  input  wire logic        i_rd_n,
  input  wire logic        i_we_n,
  input  wire logic [3:0]  i_stall,
  input  wire logic        i_port8,
  output logic [31:0]      o_data,
  output logic             o_wait_n,
  output logic             o_io16_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0]  wcnt = 0;
  logic [25:0] last_a;
  logic        last_rd;
  logic        last_we;
  logic [31:0] last_d;
  logic        start;
  // a new address or strobe edge starts a wait stretch
  assign start = i_cs_any && (i_addr != last_a || (!i_rd_n && last_rd) || (!i_we_n && last_we));
  assign o_wait_n = !(start && i_stall != 0) && wcnt == 0;
  // released bus shows a toggling pattern, not the last value
  assign o_data = !i_rd_n ? {4{i_addr[7:0]}} : ~last_d;
  assign o_io16_n = i_port8;
  // history of pins and wait counter
  always_ff @(posedge i_clk) begin
    last_a <= i_addr;
    last_rd <= i_rd_n;
    last_we <= i_we_n;
    last_d <= o_data;
    wcnt <= (start && i_stall != 0) ? i_stall - 4'h1 : wcnt - 4'(wcnt != 0);
  end
endmodule

// File: bench/tb_top.sv
// Purpose: self-checking bench for the access engine
// Assumes: engine is idle and ready between requests
// Notes:   far side returns the address byte as data
module tb_top
  import ebus_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 0, i_resetn = 0, i_req_valid = 0;
  req_t i_req = '0;
  logic [1:0] i_area0_burst_count = 0, i_area5_burst_count = 0, i_area6_burst_count = 0;
  logic [1:0] i_area0_width = WID_32;
  logic i_area5_card_enable = 0, i_area6_card_enable = 0, i_area5_width_sel = 1;
  logic i_area6_width_sel = 1, i_sdram_bus16 = 0, i_little_endian = 1, port8 = 0;
  logic [3:0] i_wait_states = 0, i_card_setup = 0, i_card_hold = 0, stall = 0;
  logic i_wait_n, i_io16_n, o_req_ready, o_done, o_rd_valid, o_rd_n, o_we_n;
  logic o_io_cycle, o_data_oe, woe;
  logic [31:0] i_data, o_rdata, o_data, rd, wd;
  logic [25:0] o_addr, mrs_addr, last_a;
  logic [6:0] o_cs_n, scs;
  sdcmd_t o_sd_cmd;
  int cyc, nstb, nrv, pall_at, mrs_at, ios, base, bref, sref, e;
  int miscompares = 0, total_checks = 0;

  always #25 i_clk = ~i_clk;
  ebus_engine dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_req_valid(i_req_valid),
    .i_req(i_req), .o_req_ready(o_req_ready), .o_done(o_done), .o_rd_valid(o_rd_valid),
    .o_rdata(o_rdata), .i_area0_burst_count(i_area0_burst_count),
    .i_area5_burst_count(i_area5_burst_count), .i_area6_burst_count(i_area6_burst_count),
    .i_area0_width(i_area0_width), .i_area5_card_enable(i_area5_card_enable),
    .i_area6_card_enable(i_area6_card_enable), .i_area5_width_sel(i_area5_width_sel),
    .i_area6_width_sel(i_area6_width_sel), .i_sdram_bus16(i_sdram_bus16),
    .i_little_endian(i_little_endian), .i_wait_states(i_wait_states),
    .i_card_setup(i_card_setup), .i_card_hold(i_card_hold), .i_wait_n(i_wait_n),
    .i_io16_n(i_io16_n), .i_data(i_data), .o_addr(o_addr), .o_cs_n(o_cs_n),
    .o_rd_n(o_rd_n), .o_we_n(o_we_n), .o_io_cycle(o_io_cycle), .o_data(o_data),
    .o_data_oe(o_data_oe), .o_sd_cmd(o_sd_cmd));
  ext_mem_model far (.i_clk(i_clk), .i_addr(o_addr), .i_cs_any(o_cs_n != CS_IDLE),
    .i_rd_n(o_rd_n), .i_we_n(o_we_n), .i_stall(stall), .i_port8(port8),
    .o_data(i_data), .o_wait_n(i_wait_n), .o_io16_n(i_io16_n));

  // compare one value and count it
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one request, then watch the pins until done
  task automatic acc(input logic [31:0] a, input logic w, input logic [1:0] sz,
                     input logic nw);
    logic pr, pw;
    i_req = '{a, w, sz, 32'h0000a55a, nw};
    i_req_valid = 1;
    @(posedge i_clk);
    #1 i_req_valid = 0;
    {cyc, nstb, nrv, pall_at, mrs_at, ios} = '0;
    {wd, woe, scs} = '0;
    pr = 1;
    pw = 1;
    repeat (300) begin
      cyc++;
      if (o_sd_cmd === CMD_PALL) pall_at = cyc;
      if (o_sd_cmd === CMD_MRS) mrs_at = cyc;
      if (o_sd_cmd === CMD_MRS) mrs_addr = o_addr;
      if ((o_rd_n === 0 && pr) || (o_we_n === 0 && pw)) nstb++;
      // last address and selects seen while a strobe is low
      if (o_rd_n === 0 || o_we_n === 0) begin
        last_a = o_addr;
        scs = o_cs_n;
      end
      if (o_we_n === 0) begin
        wd = o_data;
        woe = o_data_oe;
      end
      if (o_rd_valid === 1) nrv++;
      if (o_rd_valid === 1) rd = o_rdata;
      if (o_io_cycle === 1) ios++;
      pr = o_rd_n;
      pw = o_we_n;
      if (o_done === 1) break;
      @(posedge i_clk);
      #1;
    end
    chk("done", 1, o_done);
  endtask

  // print counts and verdict, then stop
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge i_clk);
    #1 i_resetn = 1;
    // refresh is not this engine's: the host runs its dummy refreshes first
    for (int b = 0; b < 2; b++)
      for (int c = 1; c < 4; c++) begin
        i_sdram_bus16 = b[0];
        e = b ? 'h400 | c << 5 : 'h800 | c << 6;
        acc({c[0] ? MODE_WIN_A2 : MODE_WIN_A3, e[11:0]}, 1, SZ_BYTE, 0);
        chk("precharge", 1, pall_at);
        chk("mode cmd", 2, mrs_at);
        chk("mode addr", e, mrs_addr);
      end
    acc({MODE_WIN_A2, 12'h880}, 1, SZ_WORD, 0);
    chk("no precharge", 0, pall_at);
    // burst rom beats and spacing for every width and count
    for (int w = 1; w < 4; w++)
      for (int c = 0; c < 4; c++) begin
        i_area0_width = w[1:0];
        i_area0_burst_count = c[1:0];
        acc('h100, 0, SZ_BYTE, 0);
        if (c == 0) base = cyc;
        e = c == 0 ? 1 : (2 << c) < (32 >> w) ? 2 << c : 32 >> w;
        chk("beats", e, nrv);
        chk("strobes", 1, nstb);
        chk("beat cycles", base + 2 * (e - 1), cyc);
        if (w == 3 && c == 1) bref = cyc;
      end
    sref = base;
    // wait pin per beat position, and the no-wait override
    stall = 3;
    acc('h100, 0, SZ_BYTE, 0);
    chk("later waits", 1, cyc > bref);
    acc('h100, 0, SZ_BYTE, 1);
    chk("no wait", bref, cyc);
    i_area0_burst_count = 0;
    acc('h100, 0, SZ_BYTE, 0);
    chk("first beat", sref, cyc);
    i_wait_states = 1;
    acc('h100, 0, SZ_BYTE, 0);
    chk("first waits", 1, cyc > sref + 1);
    // card area 5: setup, hold, software waits, page burst
    stall = 0;
    i_wait_states = 0;
    i_area5_card_enable = 1;
    acc('h14000040, 0, SZ_WORD, 0);
    base = cyc;
    chk("mem timing", 0, ios);
    chk("card cs", 'h5f, scs);
    acc('h15000040, 0, SZ_WORD, 0);
    chk("attr a24", 1, last_a[24]);
    i_card_setup = 2;
    i_card_hold = 1;
    acc('h14000040, 0, SZ_WORD, 0);
    chk("setup hold", base + 3, cyc);
    {i_card_setup, i_card_hold, i_wait_states} = 12'h002;
    acc('h14000040, 0, SZ_WORD, 0);
    chk("soft waits", base + 2, cyc);
    i_wait_states = 0;
    i_area5_burst_count = 1;
    acc('h14000040, 0, SZ_WORD, 0);
    chk("card burst", 4, nrv);
    acc('h14000040, 1, SZ_WORD, 0);
    chk("write single", 1, nstb);
    chk("write beats", base, cyc);
    chk("write data", 'ha55a, wd);
    chk("write oe", 1, woe);
    // io card word on an 8-bit port splits in two
    i_area5_burst_count = 0;
    port8 = 1;
    acc('h16000010, 0, SZ_WORD, 0);
    chk("split", base + 1, cyc);
    chk("second addr", 'h2000011, last_a);
    chk("split data", 'h1110, rd[15:0]);
    chk("io timing", 1, ios > 0);
    acc('h16000010, 1, SZ_WORD, 0);
    chk("split wdata", 'ha5, wd);
    chk("split write", base + 1, cyc);
    port8 = 0;
    acc('h16000010, 0, SZ_WORD, 0);
    chk("whole word", 1, nstb);
    chk("whole cycles", base, cyc);
    i_area5_card_enable = 0;
    acc('h16000010, 0, SZ_WORD, 0);
    chk("card off", 0, ios);
    i_area6_card_enable = 1;
    acc('h1a000010, 0, SZ_WORD, 0);
    chk("area6 io", 1, ios > 0);
    i_little_endian = 0;
    acc('h1a000010, 0, SZ_WORD, 0);
    chk("big endian", base, cyc);
    print_verdict();
  end

  // hang guard, well past the expected run length
  initial begin
    repeat (40000) @(posedge i_clk);
    miscompares++;
    print_verdict();
  end
endmodule

// File: rtl/ebus_engine.sv
// Purpose: sdram mode set, burst rom and card access engine
// Assumes: one request at a time, pins timed on i_clk
// Notes:   setup/hold counts apply to card areas only
// Function
// - byte write to mode window sets mode
// - precharge all, then mode set next cycle
// - 32-bit mode address field layout
// - 16-bit mode address field layout
// - nonzero burst count enables burst rom
// - chip select held, only address steps
// - burst length limited by rom width
// - wait pin sampled per burst position
// - later burst beats take at least two cycles
// - wait ignored for dma and write-back
// - card enable makes area a card port
// - card width eight or sixteen bits
// - card setup, hold and waits applied
// - card page burst for reads only
// - i/o windows use i/o card timing
// - high io16 splits word into bytes, little endian only
module ebus_engine
  import ebus_pkg::*;
#(
  parameter int WAIT_W = 4
) (
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  input  wire logic              i_req_valid,
  input  wire req_t              i_req,
  output logic                   o_req_ready,
  output logic                   o_done,
  output logic                   o_rd_valid,
  output logic [31:0]            o_rdata,
  input  wire logic [1:0]        i_area0_burst_count,
  input  wire logic [1:0]        i_area5_burst_count,
  input  wire logic [1:0]        i_area6_burst_count,
  input  wire logic [1:0]        i_area0_width,
  input  wire logic              i_area5_card_enable,
  input  wire logic              i_area6_card_enable,
  input  wire logic              i_area5_width_sel,
  input  wire logic              i_area6_width_sel,
  input  wire logic              i_sdram_bus16,
  input  wire logic              i_little_endian,
  input  wire logic [WAIT_W-1:0] i_wait_states,
  input  wire logic [WAIT_W-1:0] i_card_setup,
  input  wire logic [WAIT_W-1:0] i_card_hold,
  input  wire logic              i_wait_n,
  input  wire logic              i_io16_n,
  input  wire logic [31:0]       i_data,
  output logic [25:0]            o_addr,
  output logic [6:0]             o_cs_n,
  output logic                   o_rd_n,
  output logic                   o_we_n,
  output logic                   o_io_cycle,
  output logic [31:0]            o_data,
  output logic                   o_data_oe,
  output sdcmd_t                 o_sd_cmd
);

  // refuse counter widths the wait logic cannot serve
  if (WAIT_W < 2 || WAIT_W > 8) begin : g_wait_w_check
    $error("WAIT_W must lie in 2..8");
  end

  // beats in a burst from count code and port width
  function automatic logic [4:0] burst_len(input logic [1:0] cnt, input logic [1:0] wid);
    logic [4:0] n;
    n = 5'h1;
    case (cnt)
      2'h1:    n = 5'h4;
      2'h2:    n = 5'h8;
      2'h3:    n = 5'h10;
      default: n = 5'h1;
    endcase
    if (wid == WID_32 && n > 5'h4) begin
      n = 5'h4;
    end
    if (wid == WID_16 && n > 5'h8) begin
      n = 5'h8;
    end
    return n;
  endfunction

  // address step per beat in bytes
  function automatic logic [25:0] wid_step(input logic [1:0] wid);
    case (wid)
      WID_16:  return 26'h2;
      WID_32:  return 26'h4;
      default: return 26'h1;
    endcase
  endfunction

  state_t            state;
  logic [WAIT_W-1:0] cnt;
  logic [4:0]        beats;
  logic              first;
  logic              split;
  logic              second;
  logic              write;
  logic              no_wait;
  logic              card;
  logic [1:0]        wid;
  logic [25:0]       step;
  logic [31:0]       wdata;

  // request decode
  logic [2:0]  area;
  logic        mode_win;
  logic        is_card;
  logic        is_io;
  logic [1:0]  dec_wid;
  logic [1:0]  dec_cnt;
  logic [2:0]  cl;
  logic [25:0] mode_addr;
  logic        burst_ok;

  always_comb begin
    area     = i_req.addr[28:26];
    mode_win = (i_req.addr[31:12] == MODE_WIN_A2 || i_req.addr[31:12] == MODE_WIN_A3)
               && i_req.write && i_req.size == SZ_BYTE;
    is_card  = (area == AREA5 && i_area5_card_enable)
               || (area == AREA6 && i_area6_card_enable);
    is_io    = is_card && (i_req.addr[28:25] == IO_WIN_A5
               || i_req.addr[28:25] == IO_WIN_A6);
    dec_wid  = WID_32;
    dec_cnt  = 2'h0;
    case (area)
      AREA0: begin
        dec_wid = i_area0_width;
        dec_cnt = i_area0_burst_count;
      end
      AREA5: begin
        dec_wid = i_area5_width_sel ? WID_16 : WID_8;
        dec_cnt = i_area5_burst_count;
      end
      AREA6: begin
        dec_wid = i_area6_width_sel ? WID_16 : WID_8;
        dec_cnt = i_area6_burst_count;
      end
      default: begin
        dec_wid = WID_32;
        dec_cnt = 2'h0;
      end
    endcase
    // page burst on reads only, never for i/o cycles
    burst_ok = !i_req.write && !is_io && dec_cnt != 2'h0;
    // latency is the offset field the software chose
    if (i_sdram_bus16) begin
      cl        = i_req.addr[CL_POS_16+:3];
      mode_addr = {11'h0, MODE_WRITE_CODE, cl, MODE_SEQ_TYPE,
                   MODE_BURST_ONE, 1'b0};
    end else begin
      cl        = i_req.addr[CL_POS_32+:3];
      mode_addr = {10'h0, MODE_WRITE_CODE, cl, MODE_SEQ_TYPE,
                   MODE_BURST_ONE, 2'b00};
    end
  end

  assign o_req_ready = (state == ST_IDLE);

  // strobe phase control
  logic sample;
  logic beat_end;
  logic want_split;

  always_comb begin
    // with no_wait clear, first beat samples only with waits set, later beats always
    sample     = (first ? (i_wait_states != '0) : 1'b1) && !no_wait;
    beat_end   = (state == ST_STROBE) && cnt == '0 && !(sample && !i_wait_n);
    want_split = beat_end && split && !second && i_io16_n;
  end

  // main sequencer
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state <= ST_IDLE;
      cnt   <= WAIT_W'(CNT_RST);
      beats <= BEATS_RST;
      first <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (i_req_valid) begin
            if (mode_win) begin
              state <= ST_PALL;
            end else begin
              state <= ST_SETUP;
              cnt   <= is_card ? i_card_setup : '0;
              beats <= burst_ok ? burst_len(dec_cnt, dec_wid) : 5'h1;
              first <= 1'b1;
            end
          end
        end
        ST_PALL: state <= ST_MRS;
        ST_MRS:  state <= ST_IDLE;
        ST_SETUP: begin
          if (cnt == '0) begin
            state <= ST_STROBE;
            cnt   <= i_wait_states;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        ST_STROBE: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else if (want_split) begin
            cnt   <= i_wait_states;
            first <= 1'b0;
          end else if (beat_end && beats > 5'h1) begin
            // later beats never shorter than two cycles
            beats <= beats - 5'h1;
            first <= 1'b0;
            cnt   <= (i_wait_states == '0) ? WAIT_W'(1) : i_wait_states;
          end else if (beat_end) begin
            state <= ST_HOLD;
            cnt   <= card ? i_card_hold : '0;
          end
        end
        ST_HOLD: begin
          if (cnt == '0) begin
            state <= ST_IDLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // per request attributes
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      write   <= 1'b0;
      no_wait <= 1'b0;
      card    <= 1'b0;
      wid     <= WID_32;
      step    <= ADDR_RST;
      wdata   <= DATA_RST;
      split   <= 1'b0;
      second  <= 1'b0;
    end else if (state == ST_IDLE && i_req_valid && !mode_win) begin
      write   <= i_req.write;
      no_wait <= i_req.no_wait;
      card    <= is_card;
      wid     <= dec_wid;
      step    <= wid_step(dec_wid);
      wdata   <= i_req.wdata;
      split   <= is_io && dec_wid == WID_16 && i_req.size == SZ_WORD
                 && i_little_endian;
      second  <= 1'b0;
    end else if (want_split) begin
      second <= 1'b1;
      wdata  <= {wdata[31:16], 8'h00, wdata[15:8]}; // high byte on low lane
    end
  end

  // external address and chip select
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_addr     <= ADDR_RST;
      o_cs_n     <= CS_IDLE;
      o_io_cycle <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (i_req_valid && mode_win) begin
            o_addr <= mode_addr;
          end else if (i_req_valid) begin
            o_addr     <= i_req.addr[25:0];
            o_cs_n     <= ~(7'h1 << area);
            o_io_cycle <= is_io;
          end
        end
        ST_STROBE: begin
          if (want_split) begin
            o_addr <= o_addr + 26'h1;
          end else if (beat_end && beats > 5'h1) begin
            o_addr <= o_addr + step;
          end
        end
        ST_HOLD: begin
          if (cnt == '0) begin
            o_cs_n     <= CS_IDLE;
            o_io_cycle <= 1'b0;
          end
        end
        default: o_addr <= o_addr;
      endcase
    end
  end

  // sdram command pins
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_sd_cmd <= CMD_NOP;
    end else if (state == ST_IDLE && i_req_valid && mode_win) begin
      o_sd_cmd <= CMD_PALL;
    end else if (state == ST_PALL) begin
      o_sd_cmd <= CMD_MRS;
    end else begin
      o_sd_cmd <= CMD_NOP;
    end
  end

  // strobes and write data, cs stays low across beats
  logic next_strobe;

  always_comb begin
    next_strobe = 1'b0;
    case (state)
      ST_SETUP:  next_strobe = (cnt == '0);
      ST_STROBE: next_strobe = !beat_end || want_split || beats > 5'h1;
      default:   next_strobe = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_rd_n    <= 1'b1;
      o_we_n    <= 1'b1;
      o_data    <= DATA_RST;
      o_data_oe <= 1'b0;
    end else begin
      o_rd_n    <= !(next_strobe && !write);
      o_we_n    <= !(next_strobe && write);
      // data held through setup and hold of a card write
      o_data_oe <= write && (state == ST_SETUP || state == ST_STROBE
                   || (state == ST_HOLD && cnt != '0));
      o_data    <= want_split ? {wdata[31:16], 8'h00, wdata[15:8]} : wdata;
    end
  end

  // read data capture and completion
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_rdata    <= DATA_RST;
      o_rd_valid <= 1'b0;
      o_done     <= 1'b0;
    end else begin
      o_rd_valid <= beat_end && !write && !want_split;
      o_done     <= (state == ST_MRS) || (state == ST_HOLD && cnt == '0);
      if (beat_end && !write) begin
        if (second) begin
          o_rdata <= {o_rdata[31:16], i_data[7:0], o_rdata[7:0]};
        end else begin
          o_rdata <= i_data;
        end
      end
    end
  end

endmodule

// File: rtl/ebus_pkg.sv
// Purpose: shared constants and types for the external bus access engine
// Assumes: 32-bit internal addresses, 26 external address pins
// Notes:   sdram command codes are {ras_n, cas_n, we_n}
package ebus_pkg;
  // mode register windows, address bits 31:12
  localparam logic [19:0] MODE_WIN_A2 = 20'hffffd;
  localparam logic [19:0] MODE_WIN_A3 = 20'hffffe;
  // burst read / single write code for the mode command
  localparam logic [6:0]  MODE_WRITE_CODE = 7'h04;
  localparam logic        MODE_SEQ_TYPE   = 1'h0;
  localparam logic [2:0]  MODE_BURST_ONE  = 3'h0;
  // cas latency field position inside the written offset
  localparam int          CL_POS_32 = 6;
  localparam int          CL_POS_16 = 5;
  // area numbers, taken from address bits 28:26
  localparam logic [2:0]  AREA0 = 3'h0;
  localparam logic [2:0]  AREA5 = 3'h5;
  localparam logic [2:0]  AREA6 = 3'h6;
  // i/o card windows, address bits 28:25
  localparam logic [3:0]  IO_WIN_A5 = 4'hb;
  localparam logic [3:0]  IO_WIN_A6 = 4'hd;
  // access sizes
  localparam logic [1:0]  SZ_BYTE = 2'h0;
  localparam logic [1:0]  SZ_WORD = 2'h1;
  localparam logic [1:0]  SZ_LONG = 2'h2;
  // port width codes
  localparam logic [1:0]  WID_8  = 2'h1;
  localparam logic [1:0]  WID_16 = 2'h2;
  localparam logic [1:0]  WID_32 = 2'h3;
  // reset values
  localparam logic [6:0]  CS_IDLE   = 7'h7f;
  localparam logic [25:0] ADDR_RST  = 26'h0;
  localparam logic [31:0] DATA_RST  = 32'h0;
  localparam logic [3:0]  CNT_RST   = 4'h0;
  localparam logic [4:0]  BEATS_RST = 5'h0;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_PALL   = 3'h1,
    ST_MRS    = 3'h2,
    ST_SETUP  = 3'h3,
    ST_STROBE = 3'h4,
    ST_HOLD   = 3'h5
  } state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic [1:0]  size;
    logic [31:0] wdata;
    logic        no_wait;
  } req_t;

  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic we_n;
  } sdcmd_t;

  localparam sdcmd_t CMD_NOP  = 3'h7;
  localparam sdcmd_t CMD_PALL = 3'h2;
  localparam sdcmd_t CMD_MRS  = 3'h0;
endpackage
